// *** spc_pkg.sv ***
// constants for the serial port control block
package spc_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CFG = 8'ha1;
  localparam logic [7:0] ADDR_DIV = 8'ha2;
  localparam logic [7:0] ADDR_DAT = 8'ha3;
  localparam logic [7:0] ADDR_CTL = 8'hf8;
  // control register bit positions
  localparam int CTL_DONE = 7;
  localparam int CTL_WRITE_COLLISION_FLAG = 6;
  localparam int CTL_MODE_FAULT_FLAG = 5;
  localparam int CTL_OVR = 4;
  localparam int CTL_MODE_HI = 3;
  localparam int CTL_MODE_LO = 2;
  localparam int CTL_TXE = 1;
  localparam int CTL_EN = 0;
  // configuration register bit positions
  localparam int CFG_BUSY = 7;
  localparam int CFG_MST = 6;
  localparam int CFG_PHA = 5;
  localparam int CFG_POL = 4;
  localparam int CFG_SEL = 3;
  localparam int CFG_NSSIN = 2;
  localparam int CFG_SRMT = 1;
  localparam int CFG_RXE = 0;
  // select modes
  localparam logic [1:0] MODE_3WIRE = 2'h0;
  localparam logic [1:0] MODE_MULTI = 2'h1;
  // reset values
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [1:0] MODE_RST = MODE_MULTI;
  localparam logic [3:0] PIN_RST = 4'h8;
  // pin vector positions
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_NSS = 3;
  // timing
  localparam int T_SYSTEM_CLOCK_NS = 100;
  localparam int SLH_MIN_NS = 600;
  localparam int SLAVE_PIPE_CYC = 5;
  localparam int SLH_MIN_CYC = (SLH_MIN_NS + T_SYSTEM_CLOCK_NS - 1) / T_SYSTEM_CLOCK_NS;
  localparam logic [1:0] HOLD_CYC = 2'(SLH_MIN_CYC - SLAVE_PIPE_CYC);
  localparam logic [3:0] HALF_LAST = 4'hf;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // fifo shape
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  typedef enum logic {MST_IDLE = 1'b0, MST_RUN = 1'b1} spc_mst_e;
endpackage : spc_pkg

// *** spc_fifo.sv ***
// receive fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module spc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign inReady = count_r != (AW+1)'(D);
  assign outValid = count_r != '0;
  assign outData = mem[rdPtr_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wrPtr_r <= wrPtr_r + 1'b1;
      if (pop) rdPtr_r <= rdPtr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : spc_fifo
`default_nettype wire

// *** spc_port.sv ***
// serial peripheral port: registers, master engine, slave engine
// Notes on behaviour
// - transfer end sets done flag and event; flag holds until software clears
// - data write while transmit buffer full sets write collision flag
// - colliding write is dropped, transmit buffer unchanged
// - select low with master on and mode 01 sets mode fault and event
// - mode fault clears master enable and port enable
// - slave byte end with receive buffer full sets overrun and event
// - on overrun the older bytes stay and the new byte is lost
// - mode 00 is three-wire, select pin unused
// - mode 01 is default, select pin only an input
// - mode 1x drives select pin with the low mode bit
// - load clears transmit empty; move to shifter sets it
// - port runs only while port enable is 1
// - master clock is system clock over 2 times (divider plus one)
// - divider only used as master
// - data write loads transmit buffer and, with master on, starts a master transfer
// - data read returns the receive buffer
// - slave output valid within four clocks of select fall, off within four of rise
// - slave with phase 1 changes output six to eight clocks after last edge
`timescale 1ns/100ps
`default_nettype none
module spc_port (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  // event to interrupt controller
  output logic portEvent,
  // serial clock pin
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  // master out pin
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  // master in pin
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  // slave select pin
  input wire logic slaveSelectNIn,
  output logic slaveSelectNOut,
  output logic slaveSelectNOe
);
  import spc_pkg::*;

  // register state
  logic done_r, write_collision_flag_r, mode_fault_flag_r, ovr_r, en_r, txEmpty_r;
  logic mst_r, pha_r, pol_r, shLoaded_r;
  logic [1:0] mode_r, hold_r;
  logic [7:0] div_r, divCnt_r, txBuf_r, txSh_r, rxSh_r, rdata_r;
  logic [3:0] half_r, s1_r, s2_r, s3_r, cln_r;
  logic [2:0] bitCnt_r;
  logic sckD_r;
  spc_mst_e state_r;
  logic fifoInReady, fifoOutValid;
  logic [7:0] fifoOutData;

  // register decode
  wire wrCtl = sfrWr && sfrAddr == ADDR_CTL;
  wire wrCfg = sfrWr && sfrAddr == ADDR_CFG;
  wire wrDiv = sfrWr && sfrAddr == ADDR_DIV;
  wire wrDat = sfrWr && sfrAddr == ADDR_DAT;
  wire rdDat = sfrRd && sfrAddr == ADDR_DAT;

  // filtered pins
  wire sckC = cln_r[PIN_SCK];
  wire mosiC = cln_r[PIN_MOSI];
  wire misoC = cln_r[PIN_MISO];
  wire nssC = cln_r[PIN_NSS];
  wire [3:0] agree = ~(s2_r ^ s3_r);

  // select mode decode
  wire modeFault = en_r && mst_r && mode_r == MODE_MULTI && !nssC;
  wire selected = (mode_r == MODE_MULTI) ? !nssC : 1'b1;

  // master engine
  wire running = state_r == MST_RUN;
  wire mstStart = !running && en_r && mst_r && !txEmpty_r;
  wire tick = running && divCnt_r == div_r;
  wire mstSample = tick && !half_r[0];
  wire mstShift = tick && half_r[0] && half_r != HALF_LAST;
  wire mstDone = tick && half_r == HALF_LAST;

  // slave engine
  wire slvAct = en_r && !mst_r && selected;
  wire sckChg = sckC != sckD_r;
  wire lead = slvAct && sckChg && sckD_r == pol_r;
  wire trail = slvAct && sckChg && sckD_r != pol_r;
  wire slvSample = pha_r ? trail : lead;
  wire slvShift = (pha_r ? lead : trail) && bitCnt_r != 3'h0;
  wire slvDone = slvSample && bitCnt_r == BIT_LAST;
  wire slvLoad = en_r && !mst_r && !shLoaded_r && !txEmpty_r && hold_r == 2'h0;

  // shared data path
  wire shLoad = mstStart || slvLoad;
  wire shShift = mstShift || slvShift;
  wire sample = mstSample || slvSample;
  wire inBit = mst_r ? misoC : mosiC;
  wire xferDone = mstDone || slvDone;
  wire [7:0] rxByte = mstDone ? rxSh_r : {rxSh_r[6:0], mosiC};
  wire overrun = slvDone && !fifoInReady;
  wire txAccept = wrDat && txEmpty_r;
  wire collide = wrDat && !txEmpty_r;

  // register read mux
  wire busy = running || bitCnt_r != 3'h0;
  wire srmt = mst_r || (!shLoaded_r && bitCnt_r == 3'h0);
  wire rxe = mst_r || !fifoOutValid;
  wire [7:0] ctlByte = {done_r, write_collision_flag_r, mode_fault_flag_r, ovr_r, mode_r, txEmpty_r, en_r};
  wire [7:0] cfgByte = {busy, mst_r, pha_r, pol_r, !nssC, s2_r[PIN_NSS], srmt, rxe};
  wire [7:0] rdMux = (sfrAddr == ADDR_CTL) ? ctlByte :
                     (sfrAddr == ADDR_CFG) ? cfgByte :
                     (sfrAddr == ADDR_DIV) ? div_r :
                     (sfrAddr == ADDR_DAT) ? fifoOutData : 8'h00;

  // pin drive
  assign sckOut = running ? (pol_r ^ (pha_r ? !half_r[0] : half_r[0])) : pol_r;
  assign sckOe = en_r && mst_r;
  assign mosiOut = txSh_r[7];
  assign mosiOe = en_r && mst_r;
  assign misoOut = txSh_r[7];
  assign misoOe = slvAct;
  assign slaveSelectNOut = mode_r[0];
  assign slaveSelectNOe = en_r && mode_r[1];
  assign portEvent = done_r || write_collision_flag_r || mode_fault_flag_r || ovr_r;
  assign sfrRdata = rdata_r;

  // pin synchronisers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= PIN_RST;
      s2_r <= PIN_RST;
      s3_r <= PIN_RST;
      cln_r <= PIN_RST;
      sckD_r <= 1'b0;
    end else begin
      s1_r <= {slaveSelectNIn, misoIn, mosiIn, sckIn};
      s2_r <= s1_r;
      s3_r <= s2_r;
      cln_r <= (agree & s3_r) | (~agree & cln_r);
      sckD_r <= sckC;
    end
  end

  // control register flags, set wins over clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      done_r <= xferDone || (wrCtl ? sfrWdata[CTL_DONE] : done_r);
      write_collision_flag_r <= collide || (wrCtl ? sfrWdata[CTL_WRITE_COLLISION_FLAG] : write_collision_flag_r);
      mode_fault_flag_r <= modeFault || (wrCtl ? sfrWdata[CTL_MODE_FAULT_FLAG] : mode_fault_flag_r);
      ovr_r <= overrun || (wrCtl ? sfrWdata[CTL_OVR] : ovr_r);
    end
  end

  // enables and configuration
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_r <= 1'b0;
      mode_r <= MODE_RST;
      mst_r <= 1'b0;
      pha_r <= 1'b0;
      pol_r <= 1'b0;
      div_r <= DIV_RST;
    end else begin
      en_r <= !modeFault && (wrCtl ? sfrWdata[CTL_EN] : en_r);
      mst_r <= !modeFault && (wrCfg ? sfrWdata[CFG_MST] : mst_r);
      if (wrCtl) mode_r <= sfrWdata[CTL_MODE_HI:CTL_MODE_LO];
      if (wrCfg) pha_r <= sfrWdata[CFG_PHA];
      if (wrCfg) pol_r <= sfrWdata[CFG_POL];
      if (wrDiv) div_r <= sfrWdata;
    end
  end

  // transmit buffer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txEmpty_r <= 1'b1;
      txBuf_r <= 8'h00;
    end else begin
      if (txAccept) txBuf_r <= sfrWdata;
      if (txAccept) txEmpty_r <= 1'b0;
      else if (shLoad) txEmpty_r <= 1'b1;
    end
  end

  // read data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rdata_r <= 8'h00;
    else if (sfrRd) rdata_r <= rdMux;
  end

  // shift registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txSh_r <= 8'h00;
      rxSh_r <= 8'h00;
    end else begin
      if (shLoad) txSh_r <= txBuf_r;
      else if (shShift) txSh_r <= {txSh_r[6:0], 1'b0};
      if (sample) rxSh_r <= {rxSh_r[6:0], inBit};
    end
  end

  // master sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= MST_IDLE;
      divCnt_r <= 8'h00;
      half_r <= 4'h0;
    end else begin
      case (state_r)
        MST_IDLE: begin
          if (mstStart) state_r <= MST_RUN;
        end
        MST_RUN: begin
          if (!en_r || !mst_r || mstDone) state_r <= MST_IDLE;
        end
        default: begin
          state_r <= MST_IDLE;
        end
      endcase
      if (mstStart || tick) divCnt_r <= 8'h00;
      else if (running) divCnt_r <= divCnt_r + 8'h01;
      if (mstStart) half_r <= 4'h0;
      else if (tick) half_r <= half_r + 4'h1;
    end
  end

  // slave bit counter and output hold
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bitCnt_r <= 3'h0;
      shLoaded_r <= 1'b0;
      hold_r <= 2'h0;
    end else begin
      if (!slvAct) bitCnt_r <= 3'h0;
      else if (slvSample) bitCnt_r <= bitCnt_r + 3'h1;
      if (slvLoad) shLoaded_r <= 1'b1;
      else if (slvDone) shLoaded_r <= 1'b0;
      if (slvDone && pha_r) hold_r <= HOLD_CYC;
      else if (hold_r != 2'h0) hold_r <= hold_r - 2'h1;
    end
  end

  spc_fifo #(.W(FIFO_W), .D(FIFO_D)) rxFifo (
    .clk(clk),
    .resetn(resetn),
    .inValid(xferDone),
    .inReady(fifoInReady),
    .inData(rxByte),
    .outValid(fifoOutValid),
    .outReady(rdDat),
    .outData(fifoOutData)
  );

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence slhWait;
    !slvLoad ##1 slvLoad;
  endsequence

  a_done_sticky: assert property (
    done_r && !(wrCtl && !sfrWdata[CTL_DONE]) |=> done_r)
    else $error("done flag dropped");
  a_write_collision_flag_keep: assert property (
    collide |=> write_collision_flag_r && txBuf_r == $past(txBuf_r) && txEmpty_r == $past(shLoad))
    else $error("collision not flagged or buffer changed");
  a_mode_fault_flag_off: assert property (
    modeFault |=> mode_fault_flag_r && !mst_r && !en_r)
    else $error("mode fault did not disable port");
  a_ovr_set: assert property (overrun |=> ovr_r && portEvent)
    else $error("overrun not flagged");
  a_ovr_keep: assert property (
    overrun && !rdDat |=> fifoOutValid && fifoOutData == $past(fifoOutData))
    else $error("older byte lost on overrun");
  a_nss_drive: assert property (
    en_r && mode_r[1] |-> slaveSelectNOe && slaveSelectNOut == mode_r[0])
    else $error("select output wrong");
  a_nss_input: assert property (mode_r == MODE_MULTI |-> !slaveSelectNOe)
    else $error("select driven in input mode");
  a_txe_load: assert property (
    txAccept |=> !txEmpty_r ##[1:3] txEmpty_r || !en_r || !mst_r || running)
    else $error("transmit empty not cleared");
  a_port_off: assert property (
    !en_r |-> !sckOe && !mosiOe && !misoOe && !running)
    else $error("port active while disabled");
  a_mst_start: assert property (
    txAccept && en_r && mst_r && !running |=> ##1 running && txEmpty_r)
    else $error("master write did not start");
  a_div_tick: assert property (
    running && divCnt_r != div_r |=> $stable(sckOut) || !running)
    else $error("master clock changed early");
  a_read_rx: assert property (
    rdDat |=> sfrRdata == $past(fifoOutData))
    else $error("data read not receive buffer");
  a_slh_wait: assert property (
    slvDone && pha_r && !txEmpty_r && !mst_r |=> slhWait)
    else $error("phase one output change timing");
endmodule : spc_port
`default_nettype wire

// *** spc_partner.sv ***
// external serial slave model answering master transfers
`timescale 1ns/100ps
`default_nettype none
module spc_partner (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial link
  input wire logic sck,
  input wire logic mosi,
  input wire logic selN,
  output logic miso,
  // byte side
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte,
  output logic [3:0] nBits
);
  logic sckQ_r;
  logic lastMiso_r;
  logic [7:0] sh_r;
  // released line shows no stale value
  assign miso = selN ? ~lastMiso_r : sh_r[7];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sckQ_r <= 1'h0;
      lastMiso_r <= 1'h0;
      sh_r <= 8'h00;
      rxByte <= 8'h00;
      nBits <= 4'h0;
    end else begin
      sckQ_r <= sck;
      lastMiso_r <= miso;
      if (selN) begin
        sh_r <= txByte;
        nBits <= 4'h0;
      end else if (sck && !sckQ_r) begin
        rxByte <= {rxByte[6:0], mosi};
        nBits <= nBits + 4'h1;
      end else if (!sck && sckQ_r) begin
        sh_r <= {sh_r[6:0], 1'h0};
      end
    end
  end
endmodule : spc_partner
`default_nettype wire

// *** test_spi_port_control_and_timing.sv ***
// self-checking bench for the serial port control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module test_spi_port_control_and_timing;
  import spc_pkg::*;
  logic clk, resetn, sfrWr, sfrRd, sckIn, mosiIn, misoIn, slaveSelectNIn, ssLine;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, rxByte, rd;
  logic portEvent, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe;
  logic slaveSelectNOut, slaveSelectNOe;
  logic [3:0] nBits;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  assign ssLine = slaveSelectNOe ? slaveSelectNOut : 1'h1;
  spc_port DUT (.clk, .resetn, .sfrAddr, .sfrWr, .sfrRd, .sfrWdata, .sfrRdata, .portEvent,
    .sckIn, .sckOut, .sckOe, .mosiIn, .mosiOut, .mosiOe, .misoIn, .misoOut, .misoOe,
    .slaveSelectNIn, .slaveSelectNOut, .slaveSelectNOe);
  spc_partner partner (.clk, .resetn, .sck(sckOut), .mosi(mosiOut), .selN(ssLine),
    .miso(misoIn), .txByte(8'h3c), .rxByte, .nBits);
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWr <= 1'h1;
    @(posedge clk);
    sfrWr <= 1'h0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    sfrAddr <= a;
    sfrRd <= 1'h1;
    @(posedge clk);
    sfrRd <= 1'h0;
    @(negedge clk);
    rd = sfrRdata;
  endtask : rd_reg
  task automatic t_reset;
    rd_reg(ADDR_CTL); `CHK(rd, 8'h06)
    rd_reg(ADDR_DIV); `CHK(rd, DIV_RST)
    rd_reg(8'h00); `CHK(rd, 8'h00)
    `CHK(sckOe, 1'h0)
  endtask : t_reset
  task automatic t_master;
    int n;
    int k;
    wr(ADDR_DIV, 8'h07);
    rd_reg(ADDR_DIV); `CHK(rd, 8'h07)
    wr(ADDR_CFG, 8'h40);
    wr(ADDR_CTL, 8'h09);
    @(negedge clk); `CHK({slaveSelectNOe, slaveSelectNOut}, 2'h2)
    `CHK(sckOe, 1'h1)
    @(posedge clk);
    sfrAddr <= ADDR_DAT;
    sfrWdata <= 8'ha5;
    sfrWr <= 1'h1;
    @(posedge clk);
    sfrWdata <= 8'h5a;
    @(posedge clk);
    sfrWr <= 1'h0;
    k = 0;
    while (sckOut !== 1'h1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    n = 0;
    do begin @(negedge clk); n++; end while (sckOut === 1'h1 && n < 100);
    do begin @(negedge clk); n++; end while (sckOut === 1'h0 && n < 100);
    `CHK(n, 16)
    k = 0;
    do begin rd_reg(ADDR_CTL); k++; end while (rd[CTL_DONE] !== 1'h1 && k < 200);
    `CHK(rd[CTL_DONE], 1'h1)
    `CHK(rd[CTL_WRITE_COLLISION_FLAG], 1'h1)
    `CHK(portEvent, 1'h1)
    `CHK(rxByte, 8'ha5)
    `CHK(nBits, 4'h8)
    rd_reg(ADDR_CTL); `CHK(rd[CTL_DONE], 1'h1)
    rd_reg(ADDR_DAT); `CHK(rd, 8'h3c)
    wr(ADDR_CTL, 8'h0d);
    @(negedge clk); `CHK(slaveSelectNOut, 1'h1)
    rd_reg(ADDR_CTL); `CHK(rd & 8'hf0, 8'h00)
    wr(ADDR_CTL, 8'h04);
    @(negedge clk); `CHK(sckOe, 1'h0)
  endtask : t_master
  task automatic t_fault;
    wr(ADDR_CFG, 8'h40);
    wr(ADDR_CTL, 8'h05);
    slaveSelectNIn <= 1'h0;
    repeat (8) @(posedge clk);
    rd_reg(ADDR_CTL); `CHK(rd[CTL_MODE_FAULT_FLAG], 1'h1)
    `CHK(rd[CTL_EN], 1'h0)
    rd_reg(ADDR_CFG); `CHK(rd[CFG_MST], 1'h0)
    `CHK(portEvent, 1'h1)
    `CHK(sckOe, 1'h0)
    slaveSelectNIn <= 1'h1;
    wr(ADDR_CTL, 8'h04);
  endtask : t_fault
  task automatic slv_xfer(input logic [7:0] tx, input logic pha, output logic [7:0] rx);
    int k;
    @(posedge clk);
    slaveSelectNIn <= 1'h0;
    k = 0;
    while (misoOe !== 1'h1 && k < 5) begin @(negedge clk); k++; end
    `CHK(misoOe, 1'h1)
    repeat (2) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      mosiIn <= tx[i];
      repeat (5) @(posedge clk);
      @(negedge clk);
      if (!pha) rx[i] = misoOut;
      @(posedge clk);
      sckIn <= 1'h1;
      repeat (5) @(posedge clk);
      @(negedge clk);
      if (pha) rx[i] = misoOut;
      @(posedge clk);
      sckIn <= 1'h0;
      repeat (2) @(posedge clk);
    end
    repeat (2) @(posedge clk);
    slaveSelectNIn <= 1'h1;
    k = 0;
    while (misoOe !== 1'h0 && k < 5) begin @(negedge clk); k++; end
    `CHK(misoOe, 1'h0)
    repeat (4) @(posedge clk);
  endtask : slv_xfer
  task automatic t_slave;
    logic [7:0] rx;
    wr(ADDR_CFG, 8'h00);
    wr(ADDR_CTL, 8'h05);
    wr(ADDR_DAT, 8'h96);
    for (int i = 0; i < 17; i++) begin
      slv_xfer(8'(8'h10 + i), 1'h0, rx);
      if (i == 0) `CHK(rx, 8'h96)
    end
    rd_reg(ADDR_CTL); `CHK(rd[7:4], 4'h9)
    for (int i = 0; i < 16; i++) begin
      rd_reg(ADDR_DAT); `CHK(rd, 8'(8'h10 + i))
    end
    wr(ADDR_CTL, 8'h04);
    wr(ADDR_CFG, 8'h20);
    wr(ADDR_CTL, 8'h05);
    wr(ADDR_DAT, 8'hc3);
    wr(ADDR_DAT, 8'h69);
    rd_reg(ADDR_CTL); `CHK(rd[CTL_TXE], 1'h0)
    slv_xfer(8'h81, 1'h1, rx); `CHK(rx, 8'hc3)
    slv_xfer(8'h42, 1'h1, rx); `CHK(rx, 8'h69)
    rd_reg(ADDR_CTL); `CHK(rd[7:4], 4'h8)
    rd_reg(ADDR_DAT); `CHK(rd, 8'h81)
    rd_reg(ADDR_DAT); `CHK(rd, 8'h42)
    wr(ADDR_CTL, 8'h01);
    @(negedge clk); `CHK({misoOe, slaveSelectNOe}, 2'h2)
  endtask : t_slave
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report;
    end
  end
  initial begin
    resetn = 1'h0;
    sfrAddr = 8'h00;
    sfrWdata = 8'h00;
    sfrWr = 1'h0;
    sfrRd = 1'h0;
    sckIn = 1'h0;
    mosiIn = 1'h0;
    slaveSelectNIn = 1'h1;
    repeat (3) @(posedge clk);
    resetn <= 1'h1;
    t_reset;
    t_master;
    t_fault;
    t_slave;
    final_report;
  end
endmodule : test_spi_port_control_and_timing
`default_nettype wire
